// ---- verilog/dspbg_pkg.sv ----
package dspbg_pkg;
  // Register byte offsets
  localparam logic [5:0] OFS_CTRL0 = 6'h00;
  localparam logic [5:0] OFS_DATA0 = 6'h04;
  localparam logic [5:0] OFS_REL0_LOW = 6'h08;
  localparam logic [5:0] OFS_REL0_HIGH = 6'h0c;
  localparam logic [5:0] OFS_CTRL1 = 6'h10;
  localparam logic [5:0] OFS_DATA1 = 6'h14;
  localparam logic [5:0] OFS_REL1 = 6'h18;
  localparam logic [5:0] OFS_STATUS = 6'h1c;
  localparam logic [5:0] OFS_MASK = 6'h20;
  localparam logic [5:0] OFS_BUSY = 6'h24;

  // Control bit positions
  localparam int C_MODE = 0;
  localparam int C_RX_EN = 2;
  localparam int C_NINTH_TX = 3;
  localparam int C_NINTH_RX = 4;
  localparam int C_DOUBLE = 5;
  localparam int C_PRESC = 6;
  localparam int C_M0_RX_GO = 7;

  // Status, mask and busy bit positions
  localparam int S_TX0 = 0;
  localparam int S_RX0 = 1;
  localparam int S_TX1 = 2;
  localparam int S_RX1 = 3;
  localparam int EVT_W = 4;

  // Port 0 modes
  localparam logic [1:0] MODE_SHIFT = 2'h0;
  localparam logic [1:0] MODE_8BIT = 2'h1;
  localparam logic [1:0] MODE_9FIX = 2'h2;

  // Baud generators
  localparam int GEN_W = 10;
  localparam logic [9:0] GEN_MAX = 10'h3ff;
  // 12 MHz / (64 * (1024 - 985)) = 4.8 kBaud on port 0; port 1 divides by 32, giving 9.6 kBaud
  localparam logic [9:0] REL0_RST = 10'h3d9;
  localparam logic [9:0] REL1_RST = 10'h3d9;
  // Prescaler last counts for the x16 tick
  localparam logic [1:0] PRE_DIV4 = 2'h3;
  localparam logic [1:0] PRE_DIV2 = 2'h1;
  localparam logic [1:0] PRE_DIV1 = 2'h0;

  // Frame timing
  localparam logic [3:0] TICK_LAST = 4'hf;
  localparam logic [3:0] TICK_MID = 4'h7;
  localparam logic [3:0] FRAME10 = 4'ha;
  localparam logic [3:0] FRAME11 = 4'hb;
  localparam logic [3:0] RX_SAMPLES8 = 4'h9;
  localparam logic [3:0] RX_SAMPLES9 = 4'ha;
  localparam logic [3:0] M0_DIV_LAST = 4'hb;
  localparam logic [3:0] M0_HALF = 4'h6;
  localparam logic [2:0] M0_BIT_LAST = 3'h7;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- verilog/dspbg_top.sv ----
`timescale 1ns/1ps

module dspbg_async (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tick16,
  input wire logic nine_bit,
  input wire logic rx_en,
  input wire logic tx_start,
  input wire logic [7:0] tx_data,
  input wire logic tx_ninth,
  input wire logic rxd,
  output logic txd,
  output logic tx_busy,
  output logic rx_busy,
  output logic tx_done,
  output logic rx_done,
  output logic [7:0] rx_data,
  output logic rx_ninth
);
  typedef struct packed {
    logic tx_busy;
    logic [10:0] tx_sh;
    logic [3:0] tx_tk;
    logic [3:0] tx_left;
    logic rx_busy;
    logic rx_start;
    logic [3:0] rx_tk;
    logic [3:0] rx_left;
    logic [9:0] rx_sh;
    logic [7:0] rx_data;
    logic rx_ninth;
    logic tx_done;
    logic rx_done;
    logic txd;
  } dspbg_async_t;

  dspbg_async_t st_ff;
  dspbg_async_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.tx_done = 1'b0;
    nxt_st.rx_done = 1'b0;
    if (!st_ff.tx_busy) begin
      if (tx_start) begin
        nxt_st.tx_busy = 1'b1;
        nxt_st.tx_tk = '0;
        if (nine_bit) begin
          nxt_st.tx_sh = {1'b1, tx_ninth, tx_data, 1'b0};
          nxt_st.tx_left = dspbg_pkg::FRAME11;
        end else begin
          nxt_st.tx_sh = {2'b11, tx_data, 1'b0};
          nxt_st.tx_left = dspbg_pkg::FRAME10;
        end
      end
    end else if (tick16) begin
      if (st_ff.tx_tk == dspbg_pkg::TICK_LAST) begin
        nxt_st.tx_tk = '0;
        nxt_st.tx_sh = {1'b1, st_ff.tx_sh[10:1]};
        nxt_st.tx_left = st_ff.tx_left - 4'h1;
        if (st_ff.tx_left == 4'h1) begin
          nxt_st.tx_busy = 1'b0;
          nxt_st.tx_done = 1'b1;
        end
      end else begin
        nxt_st.tx_tk = st_ff.tx_tk + 4'h1;
      end
    end
    nxt_st.txd = nxt_st.tx_busy ? nxt_st.tx_sh[0] : 1'b1;

    if (!st_ff.rx_busy) begin
      if (rx_en && tick16 && !rxd) begin
        nxt_st.rx_busy = 1'b1;
        nxt_st.rx_start = 1'b1;
        nxt_st.rx_tk = '0;
      end
    end else if (tick16) begin
      nxt_st.rx_tk = st_ff.rx_tk + 4'h1;
      if (st_ff.rx_start) begin
        if (st_ff.rx_tk == dspbg_pkg::TICK_MID) begin
          // Glitch shorter than half a bit is not a start
          if (rxd) begin
            nxt_st.rx_busy = 1'b0;
          end else begin
            nxt_st.rx_start = 1'b0;
            nxt_st.rx_tk = '0;
            nxt_st.rx_left = nine_bit ? dspbg_pkg::RX_SAMPLES9
                                      : dspbg_pkg::RX_SAMPLES8;
          end
        end
      end else if (st_ff.rx_tk == dspbg_pkg::TICK_LAST) begin
        nxt_st.rx_tk = '0;
        nxt_st.rx_sh = {rxd, st_ff.rx_sh[9:1]};
        nxt_st.rx_left = st_ff.rx_left - 4'h1;
        if (st_ff.rx_left == 4'h1) begin
          nxt_st.rx_busy = 1'b0;
          nxt_st.rx_done = 1'b1;
          if (nine_bit) begin
            nxt_st.rx_data = nxt_st.rx_sh[7:0];
            nxt_st.rx_ninth = nxt_st.rx_sh[8];
          end else begin
            nxt_st.rx_data = nxt_st.rx_sh[8:1];
            nxt_st.rx_ninth = nxt_st.rx_sh[9];
          end
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
      st_ff.txd <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign txd = st_ff.txd;
  assign tx_busy = st_ff.tx_busy;
  assign rx_busy = st_ff.rx_busy;
  assign tx_done = st_ff.tx_done;
  assign rx_done = st_ff.rx_done;
  assign rx_data = st_ff.rx_data;
  assign rx_ninth = st_ff.rx_ninth;
endmodule

module dspbg_top #(
  parameter logic [9:0] REL0_INIT = dspbg_pkg::REL0_RST,
  parameter logic [9:0] REL1_INIT = dspbg_pkg::REL1_RST
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic timer1_overflow,
  input wire logic port0_receive_pin_i,
  output logic port0_receive_pin_o,
  output logic port0_receive_pin_oe,
  output logic port0_transmit_pin,
  input wire logic port1_receive_pin,
  output logic port1_transmit_pin,
  output logic irq
);
  typedef struct packed {
    logic aw_ok;
    logic [5:0] aw_addr;
    logic w_ok;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [1:0] c0_mode;
    logic c0_rx_en;
    logic port0_ninth_tx_flag;
    logic port0_ninth_rx_flag;
    logic rate_doubling_bit;
    logic fixed_rate_prescaler;
    logic c1_mode_b;
    logic c1_rx_en;
    logic port1_ninth_tx_flag;
    logic port1_ninth_rx_flag;
    logic [9:0] port0_reload_value;
    logic [9:0] port1_reload_value;
    logic [9:0] gen0;
    logic [9:0] gen1;
    logic [1:0] pre0;
    logic [1:0] pre1;
    logic tick0;
    logic tick1;
    logic [7:0] tx0_data;
    logic [7:0] tx1_data;
    logic tx0_go;
    logic tx1_go;
    logic [7:0] rx0_buf;
    logic [7:0] rx1_buf;
    logic [3:0] status;
    logic [3:0] mask;
    logic m0_busy;
    logic m0_rx;
    logic [3:0] m0_div;
    logic [2:0] m0_bit;
    logic [7:0] m0_sh;
    logic p0_tx;
    logic p0_rx_o;
    logic p0_rx_oe;
  } dspbg_state_t;

  dspbg_state_t st_ff;
  dspbg_state_t nxt_st;

  logic a0_txd;
  logic a0_tx_busy;
  logic a0_rx_busy;
  logic a0_tx_done;
  logic a0_rx_done;
  logic [7:0] a0_rx_data;
  logic a0_rx_ninth;
  logic a1_tx_busy;
  logic a1_rx_busy;
  logic a1_tx_done;
  logic a1_rx_done;
  logic [7:0] a1_rx_data;
  logic a1_rx_ninth;

  // Free-running up counter, reloaded after the all-ones state
  function automatic logic [9:0] gen_step(logic [9:0] cnt,
                                          logic [9:0] rel);
    gen_step = (cnt == dspbg_pkg::GEN_MAX) ? rel : cnt + 10'h001;
  endfunction

  // Returns {tick, next count} of a divide-by-(last+1) prescaler
  function automatic logic [2:0] pre_step(logic [1:0] cnt, logic pulse,
                                          logic [1:0] last);
    if (!pulse) begin
      pre_step = {1'b0, cnt};
    end else if (cnt >= last) begin
      pre_step = {1'b1, 2'b00};
    end else begin
      pre_step = {1'b0, cnt + 2'b01};
    end
  endfunction

  always_comb begin
    logic wen;
    logic ren;
    logic p0_async;
    logic src_pulse;
    logic [1:0] src_last;
    logic [2:0] pr;
    logic [3:0] evt;
    logic [3:0] clr;
    wen = st_ff.aw_ok && st_ff.w_ok && !st_ff.bvalid;
    ren = s_axi_arvalid && !st_ff.rvalid;
    p0_async = st_ff.c0_mode != dspbg_pkg::MODE_SHIFT;
    src_pulse = 1'b0;
    src_last = dspbg_pkg::PRE_DIV1;
    pr = '0;
    evt = '0;
    clr = '0;
    nxt_st = st_ff;
    nxt_st.tx0_go = 1'b0;
    nxt_st.tx1_go = 1'b0;

    // Bus channels
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_st.aw_ok = 1'b1;
      nxt_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_st.w_ok = 1'b1;
      nxt_st.w_data = s_axi_wdata;
      nxt_st.w_strb = s_axi_wstrb;
    end
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end
    if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end

    // Baud sources
    nxt_st.gen0 = gen_step(st_ff.gen0, st_ff.port0_reload_value);
    nxt_st.gen1 = gen_step(st_ff.gen1, st_ff.port1_reload_value);
    if (st_ff.c0_mode == dspbg_pkg::MODE_9FIX) begin
      src_pulse = 1'b1;
      src_last = st_ff.rate_doubling_bit ? dspbg_pkg::PRE_DIV2
                                         : dspbg_pkg::PRE_DIV4;
    end else if (st_ff.fixed_rate_prescaler) begin
      // x16 tick = gen rate * 2^double / 4
      src_pulse = st_ff.gen0 == dspbg_pkg::GEN_MAX;
      src_last = st_ff.rate_doubling_bit ? dspbg_pkg::PRE_DIV2
                                         : dspbg_pkg::PRE_DIV4;
    end else begin
      src_pulse = timer1_overflow;
      src_last = st_ff.rate_doubling_bit ? dspbg_pkg::PRE_DIV1
                                         : dspbg_pkg::PRE_DIV2;
    end
    pr = pre_step(st_ff.pre0, src_pulse, src_last);
    nxt_st.tick0 = pr[2] && p0_async;
    nxt_st.pre0 = pr[1:0];
    pr = pre_step(st_ff.pre1, st_ff.gen1 == dspbg_pkg::GEN_MAX,
                  dspbg_pkg::PRE_DIV2);
    nxt_st.tick1 = pr[2];
    nxt_st.pre1 = pr[1:0];

    // Shift register mode, 12 clocks per bit
    if (st_ff.m0_busy) begin
      if (st_ff.m0_rx && st_ff.m0_div == dspbg_pkg::M0_HALF) begin
        nxt_st.m0_sh = {port0_receive_pin_i, st_ff.m0_sh[7:1]};
      end
      if (st_ff.m0_div == dspbg_pkg::M0_DIV_LAST) begin
        nxt_st.m0_div = '0;
        nxt_st.m0_bit = st_ff.m0_bit + 3'h1;
        if (!st_ff.m0_rx) begin
          nxt_st.m0_sh = {1'b0, st_ff.m0_sh[7:1]};
        end
        if (st_ff.m0_bit == dspbg_pkg::M0_BIT_LAST) begin
          nxt_st.m0_busy = 1'b0;
          if (st_ff.m0_rx) begin
            nxt_st.rx0_buf = nxt_st.m0_sh;
            evt[dspbg_pkg::S_RX0] = 1'b1;
          end else begin
            evt[dspbg_pkg::S_TX0] = 1'b1;
          end
        end
      end else begin
        nxt_st.m0_div = st_ff.m0_div + 4'h1;
      end
    end

    // Asynchronous frame completions
    if (a0_rx_done) begin
      nxt_st.rx0_buf = a0_rx_data;
      nxt_st.port0_ninth_rx_flag = a0_rx_ninth;
    end
    if (a1_rx_done) begin
      nxt_st.rx1_buf = a1_rx_data;
      nxt_st.port1_ninth_rx_flag = a1_rx_ninth;
    end
    evt[dspbg_pkg::S_TX0] = evt[dspbg_pkg::S_TX0] | a0_tx_done;
    evt[dspbg_pkg::S_RX0] = evt[dspbg_pkg::S_RX0] | a0_rx_done;
    evt[dspbg_pkg::S_TX1] = a1_tx_done;
    evt[dspbg_pkg::S_RX1] = a1_rx_done;

    // Register write
    if (wen) begin
      nxt_st.aw_ok = 1'b0;
      nxt_st.w_ok = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = dspbg_pkg::RESP_OKAY;
      unique case (st_ff.aw_addr)
        dspbg_pkg::OFS_CTRL0: if (st_ff.w_strb[0]) begin
          nxt_st.c0_mode = st_ff.w_data[dspbg_pkg::C_MODE +: 2];
          nxt_st.c0_rx_en = st_ff.w_data[dspbg_pkg::C_RX_EN];
          nxt_st.port0_ninth_tx_flag = st_ff.w_data[dspbg_pkg::C_NINTH_TX];
          nxt_st.rate_doubling_bit = st_ff.w_data[dspbg_pkg::C_DOUBLE];
          nxt_st.fixed_rate_prescaler = st_ff.w_data[dspbg_pkg::C_PRESC];
          if (st_ff.w_data[dspbg_pkg::C_M0_RX_GO] && !st_ff.m0_busy
              && st_ff.w_data[dspbg_pkg::C_MODE +: 2]
                 == dspbg_pkg::MODE_SHIFT) begin
            nxt_st.m0_busy = 1'b1;
            nxt_st.m0_rx = 1'b1;
            nxt_st.m0_div = '0;
            nxt_st.m0_bit = '0;
          end
        end
        dspbg_pkg::OFS_DATA0: if (st_ff.w_strb[0]) begin
          if (!p0_async && !st_ff.m0_busy) begin
            nxt_st.m0_busy = 1'b1;
            nxt_st.m0_rx = 1'b0;
            nxt_st.m0_div = '0;
            nxt_st.m0_bit = '0;
            nxt_st.m0_sh = st_ff.w_data[7:0];
          end else if (p0_async && !a0_tx_busy && !st_ff.tx0_go) begin
            nxt_st.tx0_data = st_ff.w_data[7:0];
            nxt_st.tx0_go = 1'b1;
          end
        end
        dspbg_pkg::OFS_REL0_LOW: if (st_ff.w_strb[0]) begin
          nxt_st.port0_reload_value[7:0] = st_ff.w_data[7:0];
        end
        dspbg_pkg::OFS_REL0_HIGH: if (st_ff.w_strb[0]) begin
          nxt_st.port0_reload_value[9:8] = st_ff.w_data[1:0];
        end
        dspbg_pkg::OFS_CTRL1: if (st_ff.w_strb[0]) begin
          nxt_st.c1_mode_b = st_ff.w_data[dspbg_pkg::C_MODE];
          nxt_st.c1_rx_en = st_ff.w_data[dspbg_pkg::C_RX_EN];
          nxt_st.port1_ninth_tx_flag = st_ff.w_data[dspbg_pkg::C_NINTH_TX];
        end
        dspbg_pkg::OFS_DATA1: if (st_ff.w_strb[0]) begin
          if (!a1_tx_busy && !st_ff.tx1_go) begin
            nxt_st.tx1_data = st_ff.w_data[7:0];
            nxt_st.tx1_go = 1'b1;
          end
        end
        dspbg_pkg::OFS_REL1: begin
          if (st_ff.w_strb[0]) begin
            nxt_st.port1_reload_value[7:0] = st_ff.w_data[7:0];
          end
          if (st_ff.w_strb[1]) begin
            nxt_st.port1_reload_value[9:8] = st_ff.w_data[9:8];
          end
        end
        dspbg_pkg::OFS_STATUS: if (st_ff.w_strb[0]) begin
          clr = st_ff.w_data[dspbg_pkg::EVT_W-1:0];
        end
        dspbg_pkg::OFS_MASK: if (st_ff.w_strb[0]) begin
          nxt_st.mask = st_ff.w_data[dspbg_pkg::EVT_W-1:0];
        end
        dspbg_pkg::OFS_BUSY: ;
        default: nxt_st.bresp = dspbg_pkg::RESP_SLVERR;
      endcase
    end
    // New events win over a clear in the same cycle
    nxt_st.status = (st_ff.status & ~clr) | evt;

    // Register read
    if (ren) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp = dspbg_pkg::RESP_OKAY;
      nxt_st.rdata = '0;
      unique case (s_axi_araddr)
        dspbg_pkg::OFS_CTRL0: begin
          nxt_st.rdata[dspbg_pkg::C_MODE +: 2] = st_ff.c0_mode;
          nxt_st.rdata[dspbg_pkg::C_RX_EN] = st_ff.c0_rx_en;
          nxt_st.rdata[dspbg_pkg::C_NINTH_TX] = st_ff.port0_ninth_tx_flag;
          nxt_st.rdata[dspbg_pkg::C_NINTH_RX] = st_ff.port0_ninth_rx_flag;
          nxt_st.rdata[dspbg_pkg::C_DOUBLE] = st_ff.rate_doubling_bit;
          nxt_st.rdata[dspbg_pkg::C_PRESC] = st_ff.fixed_rate_prescaler;
        end
        dspbg_pkg::OFS_DATA0: nxt_st.rdata[7:0] = st_ff.rx0_buf;
        dspbg_pkg::OFS_REL0_LOW:
          nxt_st.rdata[7:0] = st_ff.port0_reload_value[7:0];
        dspbg_pkg::OFS_REL0_HIGH:
          nxt_st.rdata[1:0] = st_ff.port0_reload_value[9:8];
        dspbg_pkg::OFS_CTRL1: begin
          nxt_st.rdata[dspbg_pkg::C_MODE] = st_ff.c1_mode_b;
          nxt_st.rdata[dspbg_pkg::C_RX_EN] = st_ff.c1_rx_en;
          nxt_st.rdata[dspbg_pkg::C_NINTH_TX] = st_ff.port1_ninth_tx_flag;
          nxt_st.rdata[dspbg_pkg::C_NINTH_RX] = st_ff.port1_ninth_rx_flag;
        end
        dspbg_pkg::OFS_DATA1: nxt_st.rdata[7:0] = st_ff.rx1_buf;
        dspbg_pkg::OFS_REL1: nxt_st.rdata[9:0] = st_ff.port1_reload_value;
        dspbg_pkg::OFS_STATUS:
          nxt_st.rdata[dspbg_pkg::EVT_W-1:0] = st_ff.status;
        dspbg_pkg::OFS_MASK: nxt_st.rdata[dspbg_pkg::EVT_W-1:0] = st_ff.mask;
        dspbg_pkg::OFS_BUSY: begin
          nxt_st.rdata[dspbg_pkg::S_TX0] = a0_tx_busy
            || (st_ff.m0_busy && !st_ff.m0_rx);
          nxt_st.rdata[dspbg_pkg::S_RX0] = a0_rx_busy
            || (st_ff.m0_busy && st_ff.m0_rx);
          nxt_st.rdata[dspbg_pkg::S_TX1] = a1_tx_busy;
          nxt_st.rdata[dspbg_pkg::S_RX1] = a1_rx_busy;
        end
        default: nxt_st.rresp = dspbg_pkg::RESP_SLVERR;
      endcase
    end

    // Pins: mode 0 drives the shift clock, and the data line only while transmitting
    if (p0_async) begin
      nxt_st.p0_tx = a0_txd;
      nxt_st.p0_rx_oe = 1'b0;
      nxt_st.p0_rx_o = 1'b1;
    end else begin
      nxt_st.p0_tx = !nxt_st.m0_busy
        || (nxt_st.m0_div >= dspbg_pkg::M0_HALF);
      nxt_st.p0_rx_oe = nxt_st.m0_busy && !nxt_st.m0_rx;
      // Released data line shows idle high
      nxt_st.p0_rx_o = nxt_st.p0_rx_oe ? nxt_st.m0_sh[0] : 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
      st_ff.port0_reload_value <= REL0_INIT;
      st_ff.port1_reload_value <= REL1_INIT;
      st_ff.p0_tx <= 1'b1;
      st_ff.p0_rx_o <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  dspbg_async u_port0 (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick16(st_ff.tick0),
    .nine_bit(st_ff.c0_mode[1]),
    .rx_en(st_ff.c0_rx_en && st_ff.c0_mode != dspbg_pkg::MODE_SHIFT),
    .tx_start(st_ff.tx0_go),
    .tx_data(st_ff.tx0_data),
    .tx_ninth(st_ff.port0_ninth_tx_flag),
    .rxd(port0_receive_pin_i),
    .txd(a0_txd),
    .tx_busy(a0_tx_busy),
    .rx_busy(a0_rx_busy),
    .tx_done(a0_tx_done),
    .rx_done(a0_rx_done),
    .rx_data(a0_rx_data),
    .rx_ninth(a0_rx_ninth)
  );

  dspbg_async u_port1 (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick16(st_ff.tick1),
    .nine_bit(!st_ff.c1_mode_b),
    .rx_en(st_ff.c1_rx_en),
    .tx_start(st_ff.tx1_go),
    .tx_data(st_ff.tx1_data),
    .tx_ninth(st_ff.port1_ninth_tx_flag),
    .rxd(port1_receive_pin),
    .txd(port1_transmit_pin),
    .tx_busy(a1_tx_busy),
    .rx_busy(a1_rx_busy),
    .tx_done(a1_tx_done),
    .rx_done(a1_rx_done),
    .rx_data(a1_rx_data),
    .rx_ninth(a1_rx_ninth)
  );

  assign s_axi_awready = !st_ff.aw_ok && !st_ff.bvalid;
  assign s_axi_wready = !st_ff.w_ok && !st_ff.bvalid;
  assign s_axi_bvalid = st_ff.bvalid;
  assign s_axi_bresp = st_ff.bresp;
  assign s_axi_arready = !st_ff.rvalid;
  assign s_axi_rvalid = st_ff.rvalid;
  assign s_axi_rdata = st_ff.rdata;
  assign s_axi_rresp = st_ff.rresp;
  assign port0_transmit_pin = st_ff.p0_tx;
  assign port0_receive_pin_o = st_ff.p0_rx_o;
  assign port0_receive_pin_oe = st_ff.p0_rx_oe;
  assign irq = |(st_ff.status & st_ff.mask);
endmodule

// ---- tb/dspbg_assertions.sv ----
`timescale 1ns/1ps
module dspbg_assertions (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic port0_receive_pin_o,
  input wire logic port0_receive_pin_oe,
  input wire logic port0_transmit_pin,
  input wire logic port1_transmit_pin
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_m0_fall;
    $fell(port0_transmit_pin) && port0_receive_pin_oe;
  endsequence
  sequence s_m0_low;
    (!port0_transmit_pin) [*6] ##1 port0_transmit_pin;
  endsequence
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
  chk_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("arready during rvalid");
  chk_aw_refuse: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("awready during bvalid");
  chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read answer late");
  chk_wr_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("no bvalid");
  chk_oe_idle: assert property (!port0_receive_pin_oe |->
    port0_receive_pin_o) else $error("data line not idle");
  chk_m0_low: assert property (s_m0_fall |-> s_m0_low)
    else $error("shift clock low phase wrong");
  chk_start_len: assert property ($fell(port1_transmit_pin) |->
    (!port1_transmit_pin) [*8]) else $error("start bit short");
endmodule

bind dspbg_top dspbg_assertions u_chk (.*);

// ---- tb/dspbg_partner.sv ----
`timescale 1ns/1ps
module dspbg_partner (
  input wire logic aclk,
  output logic [1:0] line
);
  initial line = 2'b11;
  // Start first, LSB first, stop last
  task automatic send(input int p, input int per, input int n,
    input logic [10:0] f);
    for (int i = 0; i < n; i++) begin
      line[p] <= f[i];
      repeat (per) @(posedge aclk);
    end
  endtask
endmodule

// ---- tb/dspbg_top_bench.sv ----
`timescale 1ns/1ps
`define CK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin fails++; \
  $display("MISMATCH %s exp %h got %h", nm, e, s); end end
module dspbg_top_bench;
  logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  logic t1 = 0;
  logic [5:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rdat, rdw;
  logic [1:0] rrsp, brw, rrw, pl;
  logic awr, wrr, bvl, arr, rvl, p0o, p0oe, tx0, tx1, irq;
  wire p0 = p0oe ? p0o : pl[0];
  wire [1:0] txl = {tx1, tx0};
  int fails = 0, n_tests = 0;
  always #25 aclk = ~aclk;
  always @(posedge aclk) t1 <= ~t1;
  dspbg_partner u_partner (.aclk(aclk), .line(pl));
  dspbg_top #(.REL0_INIT(10'h3fe), .REL1_INIT(10'h3fe)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrr),
    .s_axi_bresp(brw), .s_axi_bvalid(bvl), .s_axi_bready(bry),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdw), .s_axi_rresp(rrw), .s_axi_rvalid(rvl),
    .s_axi_rready(rry), .timer1_overflow(t1), .port0_receive_pin_i(p0),
    .port0_receive_pin_o(p0o), .port0_receive_pin_oe(p0oe),
    .port0_transmit_pin(tx0), .port1_receive_pin(pl[1]),
    .port1_transmit_pin(tx1), .irq(irq));
  task automatic hs(ref logic s);
    logic k;
    do begin
      @(negedge aclk);
      k = s;
      rdat = rdw;
      rrsp = rrw;
      @(posedge aclk);
    end while (!k);
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    awa <= a;
    wd <= d;
    awv <= 1;
    wv <= 1;
    bry <= 1;
    fork
      begin hs(awr); awv <= 0; end
      begin hs(wrr); wv <= 0; end
    join
    hs(bvl);
    bry <= 0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [5:0] a);
    ara <= a;
    arv <= 1;
    hs(arr);
    arv <= 0;
    rry <= 1;
    hs(rvl);
    rry <= 0;
  endtask
  task automatic cap(input int p, input int per, input int n,
    output logic [10:0] f);
    int t;
    f = 0;
    t = 0;
    do begin @(negedge aclk); t++; end while (txl[p] !== 1'b0 && t < 4000);
    repeat (per / 2) @(negedge aclk);
    for (int i = 0; i < n; i++) begin
      f[i] = txl[p];
      repeat (per) @(negedge aclk);
    end
    @(posedge aclk);
  endtask
  task automatic t_regs();
    rd(dspbg_pkg::OFS_REL0_LOW);
    `CK("rel0 low", 32'h0000_00fe, rdat)
    rd(dspbg_pkg::OFS_REL0_HIGH);
    `CK("rel0 high", 32'h0000_0003, rdat)
    rd(6'h28);
    `CK("unmapped", dspbg_pkg::RESP_SLVERR, rrsp)
    `CK("rel0 reset", 10'h3d9, dspbg_pkg::REL0_RST)
    $display("t_regs done");
  endtask
  task automatic t_tx();
    logic [7:0] c [8] = '{8'h0a, 8'h2a, 8'h4b, 8'h41, 8'h61, 8'h01,
      8'h08, 8'h01};
    int per [8] = '{64, 32, 128, 128, 64, 64, 64, 64};
    logic [10:0] f, e;
    logic [7:0] d;
    int p, n;
    wr(dspbg_pkg::OFS_MASK, 32'h0000_0004);
    for (int i = 0; i < 8; i++) begin
      p = i / 6;
      d = 8'h5a + 8'(i);
      n = (p ? c[i][0] : c[i][1:0] == 2'h1) ? 10 : 11;
      e = (n == 10) ? {2'b01, d, 1'b0} : {1'b1, c[i][3], d, 1'b0};
      wr(p ? dspbg_pkg::OFS_CTRL1 : dspbg_pkg::OFS_CTRL0, {24'h0, c[i]});
      wr(p ? dspbg_pkg::OFS_DATA1 : dspbg_pkg::OFS_DATA0, {24'h0, d});
      cap(p, per[i], n, f);
      `CK("frame", e, f)
      if (i == 0) `CK("irq masked", 1'b0, irq)
    end
    `CK("irq set", 1'b1, irq)
    wr(dspbg_pkg::OFS_STATUS, 32'h0000_000f);
    `CK("irq clear", 1'b0, irq)
    $display("t_tx done");
  endtask
  task automatic t_rx();
    logic [7:0] c [4] = '{8'h06, 8'h45, 8'h04, 8'h05};
    int per [4] = '{64, 128, 64, 64};
    logic [7:0] d;
    int p, n;
    for (int i = 0; i < 4; i++) begin
      p = i / 2;
      d = 8'hc3 - 8'(i);
      n = (i == 1 || i == 3) ? 10 : 11;
      wr(p ? dspbg_pkg::OFS_CTRL1 : dspbg_pkg::OFS_CTRL0, {24'h0, c[i]});
      u_partner.send(p, per[i], n,
        (n == 10) ? {2'b01, d, 1'b0} : {2'b10, d, 1'b0});
      repeat (4) @(posedge aclk);
      rd(p ? dspbg_pkg::OFS_DATA1 : dspbg_pkg::OFS_DATA0);
      `CK("rx byte", {24'h0, d}, rdat)
      rd(p ? dspbg_pkg::OFS_CTRL1 : dspbg_pkg::OFS_CTRL0);
      `CK("ninth rx", n == 10, rdat[dspbg_pkg::C_NINTH_RX])
    end
    $display("t_rx done");
  endtask
  task automatic t_m0();
    logic [7:0] b;
    logic pv;
    int c, i;
    wr(dspbg_pkg::OFS_CTRL0, 32'h0);
    wr(dspbg_pkg::OFS_DATA0, 32'h0000_0096);
    pv = 1;
    i = 0;
    c = 0;
    while (i < 8 && c < 400) begin
      @(negedge aclk);
      c++;
      if (tx0 && !pv) begin
        b[i] = p0;
        if (i > 0) `CK("m0 gap", 12, c)
        c = 0;
        i++;
      end
      pv = tx0;
    end
    `CK("m0 byte", 8'h96, b)
    repeat (8) @(posedge aclk);
    wr(dspbg_pkg::OFS_CTRL0, 32'h0000_0080);
    u_partner.send(0, 12, 8, 11'h0a5);
    repeat (4) @(posedge aclk);
    rd(dspbg_pkg::OFS_DATA0);
    `CK("m0 rx", 32'h0000_00a5, rdat)
    $display("t_m0 done");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    t_regs();
    t_tx();
    t_rx();
    @(posedge aclk);
    t_m0();
    tally_and_finish();
  end
  initial begin
    repeat (60000) @(posedge aclk);
    fails++;
    tally_and_finish();
  end
endmodule
